// ==== hw/scl_pkg.sv ====
// Package with register map, field positions, reset values and state types of the system control block
package scl_pkg;
    // ************************************************************
    // Register map (byte addresses, one 32-bit word each)
    // ************************************************************
    localparam logic [4:0] ADDR_PMC1  = 5'h00;
    localparam logic [4:0] ADDR_PMC2  = 5'h04;
    localparam logic [4:0] ADDR_CAUSE = 5'h08;
    localparam logic [4:0] ADDR_RTI   = 5'h0C;
    localparam logic [4:0] ADDR_CLKO  = 5'h10;
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int P1_EN   = 0;
    localparam int P1_IE   = 1;
    localparam int P1_RE   = 2;
    localparam int P1_SKE  = 3;
    localparam int P1_FLAG = 4;
    localparam int P1_ACK  = 5;
    localparam int P2_LVL  = 0;
    localparam int P2_WLVL = 1;
    localparam int P2_WARN = 2;
    localparam int P2_WACK = 3;
    localparam int CA_POR  = 0;
    localparam int CA_LV   = 1;
    localparam int RT_SEL  = 0;
    localparam int RT_IE   = 3;
    localparam int RT_CKS  = 4;
    localparam int RT_FLAG = 5;
    localparam int RT_ACK  = 6;
    localparam int CO_EN   = 0;
    localparam int CO_SEL  = 1;
    // ************************************************************
    // Reset values and sizes
    // ************************************************************
    localparam logic RST_LV_EN = 1'b1;
    localparam logic RST_LV_RE = 1'b1;
    localparam int   RTI_CW    = 10;
    localparam int   DIV_CW    = 7;
    // ************************************************************
    // State types
    // ************************************************************
    typedef enum logic [2:0] {
        ST_POR = 3'b001,
        ST_LVD = 3'b010,
        ST_RUN = 3'b100
    } scl_fsm_t;
    typedef struct packed {
        scl_fsm_t            fsm;
        logic                ack;
        logic [31:0]         rdata;
        logic                lv_en, lv_ie, lv_re, lv_ske, lv_flag, lv_lvl;
        logic                warn_lvl, warn_flag, cause_por, cause_lv;
        logic [2:0]          rti_sel;
        logic                rti_ie, rti_cks, rti_flag;
        logic [RTI_CW-1:0]   rti_cnt;
        logic                lpo_s1, lpo_s2, lpo_s3, ext_s1, ext_s2, ext_s3;
        logic                mc_en;
        logic [2:0]          mc_sel;
        logic [DIV_CW-1:0]   div_cnt;
        logic                pin;
    } scl_state_t;
endpackage

// ==== hw/scl_top.sv ====
// System control: low-voltage detect control, periodic wake-up timer and divided clock output
// Overview of operation
// (R1) Detector runs only while enabled; level select picks high or low trip.
// (R2) Entering any stop mode turns the detector off unless stop keep-alive is set.
// (R3) Enable plus stop keep-alive together forbid entry to deep stop mode.
// (R4) After power-on, chip stays in reset until supply exceeds the low trip.
// (R5) Power-on sets both power-on and low-voltage cause flags.
// (R6) With reset enable, a low supply resets chip until above selected trip.
// (R7) A low-voltage reset sets the low-voltage cause flag.
// (R8) Enabled detector, interrupt on, reset off: low supply sets flag and interrupts.
// (R9) Warning flag has its own level select and never interrupts.
// (R10) Software should not pick warning level equal to detect level.
// (R11) Timer counts internal 1 kHz clock or external clock per select bit.
// (R12) Both sources work in run and light stop; oscillator setup is software's.
// (R13) Only the internal clock can advance the timer in deep stop.
// (R14) Control holds read-only flag, write-only acknowledge and 3-bit period field.
// (R15) Timer interrupt requested only while its enable is set.
// (R16) Period field zero disables timer; no events.
// (R17) Clock-out enable drives bus clock divided by select ratio on shared pin.
// (R18) Clock-out enable forces the pin to output regardless of direction bit.
// (R19) Divide select zero drives the pin low.
// (R20) Pin slew and drive follow the port's own slew and drive bits.
// (R21) A set flag with its enable set requests an interrupt.
// (R22) Period select n gives 8..1024 ticks; divide select n divides by 2^n.
// (R23) 1 kHz ticks pass a two-flop synchroniser before setting the flag.
`timescale 1ns/100ps
`default_nettype none
module scl_top
    import scl_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic [4:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_below_low,
    input  wire logic        i_below_high,
    input  wire logic        i_warn_below_low,
    input  wire logic        i_warn_below_high,
    input  wire logic        i_in_stop,
    input  wire logic        i_in_deep_stop,
    input  wire logic        i_lpo_clk,
    input  wire logic        i_ext_clk,
    input  wire logic        i_port_data,
    input  wire logic        i_port_ddr,
    input  wire logic        i_port_slew,
    input  wire logic        i_port_drive,
    output logic             o_chip_reset,
    output logic             o_lowv_detector_on,
    output logic             o_lowv_level_high,
    output logic             o_deep_stop_allowed,
    output logic             o_lowv_irq,
    output logic             o_periodic_irq,
    output logic             o_pin_out,
    output logic             o_pin_oe,
    output logic             o_pin_slew,
    output logic             o_pin_drive
);
    // ************************************************************
    // Helpers
    // ************************************************************
    // Period encodings are local; a larger select would need a wider counter
    function automatic logic [RTI_CW-1:0] rti_last(input logic [2:0] sel);
        unique case (sel)
            3'h1:    rti_last = 10'h007;
            3'h2:    rti_last = 10'h01F;
            3'h3:    rti_last = 10'h03F;
            3'h4:    rti_last = 10'h07F;
            3'h5:    rti_last = 10'h0FF;
            3'h6:    rti_last = 10'h1FF;
            default: rti_last = 10'h3FF;
        endcase
    endfunction

    scl_state_t state_ff;
    scl_state_t nxt_state;
    logic       bus_req;
    logic       wr_go;
    logic       rd_go;
    logic       running;
    logic       below_sel;
    logic       det_on;
    logic       tick;
    logic       rti_evt;
    logic       lv_trip;
    logic       warn_trip;

    assign bus_req   = i_avs_read | i_avs_write;
    assign running   = (state_ff.fsm == ST_RUN);
    // Writes land on the answering edge and are dropped while the chip is held in reset
    assign wr_go     = i_avs_write & state_ff.ack & i_avs_byteenable[0] & running;
    assign rd_go     = i_avs_read & ~state_ff.ack;
    assign below_sel = state_ff.lv_lvl ? i_below_high : i_below_low;
    assign det_on    = state_ff.lv_en & (~i_in_stop | state_ff.lv_ske); // [R1] [R2]
    assign lv_trip   = running & det_on & below_sel;
    assign warn_trip = state_ff.warn_lvl ? i_warn_below_high : i_warn_below_low;
    // Edge taken from the second and third flops; the first flop feeds only the second
    assign tick      = state_ff.rti_cks ? (state_ff.ext_s2 & ~state_ff.ext_s3 & ~i_in_deep_stop) // [R11] [R13]
                                        : (state_ff.lpo_s2 & ~state_ff.lpo_s3);                 // [R23] [R12]
    assign rti_evt   = running & (state_ff.rti_sel != 3'h0) & tick
                       & (state_ff.rti_cnt == rti_last(state_ff.rti_sel));                       // [R16] [R22]

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        nxt_state        = state_ff;
        nxt_state.ack    = bus_req & ~state_ff.ack;
        nxt_state.lpo_s1 = i_lpo_clk;
        nxt_state.lpo_s2 = state_ff.lpo_s1;
        nxt_state.lpo_s3 = state_ff.lpo_s2;
        nxt_state.ext_s1 = i_ext_clk;
        nxt_state.ext_s2 = state_ff.ext_s1;
        nxt_state.ext_s3 = state_ff.ext_s2;
        // Free-running divider; picking one bit limits ratios to powers of two
        nxt_state.div_cnt = state_ff.div_cnt + 7'h01;
        // Bus read data captured while waitrequest is high, shown on the release cycle
        if (rd_go) begin
            nxt_state.rdata = 32'h0;
            unique case (i_avs_address)
                ADDR_PMC1: begin
                    nxt_state.rdata[P1_EN]   = state_ff.lv_en;
                    nxt_state.rdata[P1_IE]   = state_ff.lv_ie;
                    nxt_state.rdata[P1_RE]   = state_ff.lv_re;
                    nxt_state.rdata[P1_SKE]  = state_ff.lv_ske;
                    nxt_state.rdata[P1_FLAG] = state_ff.lv_flag;
                end
                ADDR_PMC2: begin
                    nxt_state.rdata[P2_LVL]  = state_ff.lv_lvl;
                    nxt_state.rdata[P2_WLVL] = state_ff.warn_lvl;
                    nxt_state.rdata[P2_WARN] = state_ff.warn_flag;
                end
                ADDR_CAUSE: begin
                    nxt_state.rdata[CA_POR]  = state_ff.cause_por;
                    nxt_state.rdata[CA_LV]   = state_ff.cause_lv;
                end
                ADDR_RTI: begin
                    nxt_state.rdata[RT_SEL+2:RT_SEL] = state_ff.rti_sel;
                    nxt_state.rdata[RT_IE]   = state_ff.rti_ie;
                    nxt_state.rdata[RT_CKS]  = state_ff.rti_cks;
                    nxt_state.rdata[RT_FLAG] = state_ff.rti_flag; // [R14]
                end
                ADDR_CLKO: begin
                    nxt_state.rdata[CO_EN]   = state_ff.mc_en;
                    nxt_state.rdata[CO_SEL+2:CO_SEL] = state_ff.mc_sel;
                end
                default: nxt_state.rdata = 32'h0;
            endcase
        end
        // Register writes; acknowledges clear first so a same-cycle event still sets
        if (wr_go) begin
            unique case (i_avs_address)
                ADDR_PMC1: begin
                    nxt_state.lv_en  = i_avs_writedata[P1_EN];
                    nxt_state.lv_ie  = i_avs_writedata[P1_IE];
                    nxt_state.lv_re  = i_avs_writedata[P1_RE];
                    nxt_state.lv_ske = i_avs_writedata[P1_SKE];
                    if (i_avs_writedata[P1_ACK]) begin
                        nxt_state.lv_flag = 1'b0;
                    end
                end
                ADDR_PMC2: begin
                    nxt_state.lv_lvl   = i_avs_writedata[P2_LVL];
                    nxt_state.warn_lvl = i_avs_writedata[P2_WLVL];
                    if (i_avs_writedata[P2_WACK]) begin
                        nxt_state.warn_flag = 1'b0;
                    end
                end
                ADDR_RTI: begin
                    nxt_state.rti_sel = i_avs_writedata[RT_SEL+2:RT_SEL];
                    nxt_state.rti_ie  = i_avs_writedata[RT_IE];
                    nxt_state.rti_cks = i_avs_writedata[RT_CKS];
                    if (i_avs_writedata[RT_ACK]) begin
                        nxt_state.rti_flag = 1'b0; // [R14]
                    end
                end
                ADDR_CLKO: begin
                    nxt_state.mc_en  = i_avs_writedata[CO_EN];
                    nxt_state.mc_sel = i_avs_writedata[CO_SEL+2:CO_SEL];
                end
                default: begin
                end
            endcase
        end
        // Periodic timer
        if (state_ff.rti_sel == 3'h0) begin
            nxt_state.rti_cnt = '0; // [R16]
        end else if (tick) begin
            nxt_state.rti_cnt = rti_evt ? '0 : state_ff.rti_cnt + 10'h001;
        end
        if (rti_evt) begin
            nxt_state.rti_flag = 1'b1; // [R23]
        end
        // Low-voltage interrupt path and warning
        if (lv_trip & ~state_ff.lv_re) begin
            nxt_state.lv_flag = 1'b1; // [R8]
        end
        if (running & warn_trip) begin
            nxt_state.warn_flag = 1'b1; // [R9]
        end
        // Clock output pin, registered
        if (state_ff.mc_en) begin
            nxt_state.pin = (state_ff.mc_sel == 3'h0) ? 1'b0                               // [R19]
                          : state_ff.div_cnt[state_ff.mc_sel - 3'h1];                    // [R17] [R22]
        end else begin
            nxt_state.pin = i_port_data;
        end
        // Chip reset sequencing
        unique case (state_ff.fsm)
            // Comparator inputs are levels; any filtering is left to the analog side
            ST_POR: begin
                if (~i_below_low) begin
                    nxt_state.fsm = ST_RUN; // [R4]
                end
            end
            ST_LVD: begin
                if (~below_sel) begin
                    nxt_state.fsm = ST_RUN; // [R6]
                end
            end
            ST_RUN: begin
                if (lv_trip & state_ff.lv_re) begin
                    // Block returns to defaults except synchronisers and bus handshake; trip level kept so release uses it
                    nxt_state           = '0;
                    nxt_state.fsm       = ST_LVD;               // [R6]
                    nxt_state.lv_lvl    = state_ff.lv_lvl;
                    nxt_state.lv_en     = RST_LV_EN;
                    nxt_state.lv_re     = RST_LV_RE;
                    nxt_state.cause_lv  = 1'b1;                 // [R7]
                    nxt_state.lpo_s1    = i_lpo_clk;
                    nxt_state.lpo_s2    = state_ff.lpo_s1;
                    nxt_state.lpo_s3    = state_ff.lpo_s2;
                    nxt_state.ext_s1    = i_ext_clk;
                    nxt_state.ext_s2    = state_ff.ext_s1;
                    nxt_state.ext_s3    = state_ff.ext_s2;
                    nxt_state.ack       = bus_req & ~state_ff.ack;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            state_ff           <= '0;
            state_ff.fsm       <= ST_POR;
            state_ff.lv_en     <= RST_LV_EN;
            state_ff.lv_re     <= RST_LV_RE;
            state_ff.cause_por <= 1'b1; // [R5]
            state_ff.cause_lv  <= 1'b1; // [R5]
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign o_avs_readdata      = state_ff.rdata;
    assign o_avs_waitrequest   = bus_req & ~state_ff.ack;
    assign o_chip_reset        = ~running;
    assign o_lowv_detector_on  = det_on;
    assign o_lowv_level_high   = state_ff.lv_lvl;
    assign o_deep_stop_allowed = ~(state_ff.lv_en & state_ff.lv_ske);      // [R3]
    assign o_lowv_irq          = state_ff.lv_flag & state_ff.lv_ie;        // [R21]
    assign o_periodic_irq      = state_ff.rti_flag & state_ff.rti_ie;      // [R15] [R21]
    assign o_pin_out           = state_ff.pin;
    assign o_pin_oe            = state_ff.mc_en | i_port_ddr;              // [R18]
    // Slow slew caps the usable clock-out rate; left to software
    assign o_pin_slew          = i_port_slew;                              // [R20]
    assign o_pin_drive         = i_port_drive;                             // [R20]

    // ************************************************************
    // Assertions: reset, bus and detector
    // ************************************************************
    // Checks sleep during reset; the low-voltage hold is seen through o_chip_reset
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    a_detector_gate: assert property ((!state_ff.lv_en || (i_in_stop && !state_ff.lv_ske)) |-> !o_lowv_detector_on) // [R1]
        else $error("detector on while disabled");
    a_det_active: assert property ((state_ff.lv_en && !i_in_stop) |-> o_lowv_detector_on) // [R1]
        else $error("detector off while enabled");
    a_deep_stop_block: assert property ((state_ff.lv_en && state_ff.lv_ske) |-> !o_deep_stop_allowed) // [R3]
        else $error("deep stop allowed with keep-alive");

    a_por_hold_low: assert property ((state_ff.fsm == ST_POR && i_below_low) |=> o_chip_reset) // [R4]
        else $error("released while below low trip");
    a_por_release: assert property ((state_ff.fsm == ST_POR && !i_below_low) |=> !o_chip_reset) // [R4]
        else $error("power-on hold not released");
    a_por_cause_set: assert property ($rose(i_nrst) |-> state_ff.cause_por && state_ff.cause_lv) // [R5]
        else $error("power-on causes not set");
    a_lvd_reset_go: assert property ((lv_trip && state_ff.lv_re) |=> o_chip_reset && state_ff.cause_lv && !state_ff.cause_por) // [R6]
        else $error("low-voltage reset missing");
    a_lvd_release: assert property ((state_ff.fsm == ST_LVD && !below_sel) |=> !o_chip_reset) // [R6]
        else $error("low-voltage hold not released");

    a_lvd_flag_set: assert property ((lv_trip && !state_ff.lv_re) |=> state_ff.lv_flag) // [R8]
        else $error("low-voltage flag missing");
    a_lvd_irq_set: assert property ((lv_trip && !state_ff.lv_re && state_ff.lv_ie && !wr_go) |=> o_lowv_irq) // [R8]
        else $error("low-voltage interrupt missing");
    a_warn_level: assert property ((running && warn_trip) |=> (state_ff.warn_flag || o_chip_reset)) // [R9]
        else $error("warning flag missing");
    a_warn_no_irq: assert property (($rose(state_ff.warn_flag) && !state_ff.lv_flag) |-> !o_lowv_irq) // [R9]
        else $error("warning raised interrupt");

    a_bus_one_wait: assert property (o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("more than one wait cycle");

    // ************************************************************
    // Assertions: timer and clock output
    // ************************************************************
    a_rti_disabled: assert property ((state_ff.rti_sel == 3'h0) |=> !$rose(state_ff.rti_flag)) // [R16]
        else $error("timer event while disabled");
    a_rti_masked: assert property (!state_ff.rti_ie |-> !o_periodic_irq) // [R15]
        else $error("timer interrupt while masked");
    a_rti_sync_src: assert property ($rose(state_ff.rti_flag) |-> $past(tick)) // [R23]
        else $error("timer flag without synchronised tick");
    a_rti_event_set: assert property (rti_evt |=> (state_ff.rti_flag || o_chip_reset)) // [R14]
        else $error("timer flag missing");
    a_rti_cnt_hold: assert property ((state_ff.rti_sel != 3'h0 && !tick) // [R22]
                                     |=> ($stable(state_ff.rti_cnt) || o_chip_reset))
        else $error("timer count moved without tick");

    a_clkout_low: assert property ((state_ff.mc_en && state_ff.mc_sel == 3'h0) [*2] |-> !o_pin_out) // [R19]
        else $error("clock-out not low with zero select");
    a_clkout_dir: assert property (state_ff.mc_en |-> o_pin_oe) // [R18]
        else $error("clock-out pin not driven");
    a_clkout_follow: assert property ((state_ff.mc_en && state_ff.mc_sel == 3'h1) [*2] // [R17]
                                      |-> o_pin_out == $past(state_ff.div_cnt[0]))
        else $error("clock-out not following divider");

    c_lvd_reset: cover property (lv_trip && state_ff.lv_re);
    c_lvd_irq:   cover property ($rose(o_lowv_irq));
    c_rti_event: cover property ($rose(o_periodic_irq));
    c_clkout:    cover property (state_ff.mc_en && $rose(o_pin_out));
    c_deep_refused: cover property (i_in_stop && !o_deep_stop_allowed);
endmodule
`default_nettype wire

// ==== test/scl_core_mdl.sv ====
// Core stand-in that enters stop and deep stop on request
`timescale 1ns/100ps
`default_nettype none
module scl_core_mdl (
    input  wire logic i_clk,
    input  wire logic i_nrst,
    input  wire logic i_stop_req,
    input  wire logic i_deep_req,
    input  wire logic i_deep_stop_allowed,
    output logic      o_in_stop,
    output logic      o_in_deep_stop
);
    // Deep stop is entered only while the block allows it, then held until released
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_in_stop      <= 1'b0;
            o_in_deep_stop <= 1'b0;
        end else begin
            o_in_stop      <= i_stop_req | i_deep_req;
            o_in_deep_stop <= i_deep_req & (o_in_deep_stop | i_deep_stop_allowed);
        end
    end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking testbench of the system control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import scl_pkg::*;
    logic        clk, nrst, rd, wr, bl, bh, wl, wh, lpo, ext, pd, ddr, slw, drv, sreq, dreq, lpo_on, ext_on;
    logic        wait_rq, crst, det_on, lvl_hi, deep_ok, lv_irq, rt_irq, pin, oe, pslw, pdrv, in_stop, in_deep;
    logic        prev;
    logic [4:0]  adr;
    logic [31:0] wd, rdat, q;
    int          fails, checks_done, n;

    scl_top dut_u (
        .i_clk(clk), .i_nrst(nrst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat), .o_avs_waitrequest(wait_rq),
        .i_below_low(bl), .i_below_high(bh), .i_warn_below_low(wl), .i_warn_below_high(wh),
        .i_in_stop(in_stop), .i_in_deep_stop(in_deep), .i_lpo_clk(lpo), .i_ext_clk(ext),
        .i_port_data(pd), .i_port_ddr(ddr), .i_port_slew(slw), .i_port_drive(drv),
        .o_chip_reset(crst), .o_lowv_detector_on(det_on), .o_lowv_level_high(lvl_hi),
        .o_deep_stop_allowed(deep_ok), .o_lowv_irq(lv_irq), .o_periodic_irq(rt_irq),
        .o_pin_out(pin), .o_pin_oe(oe), .o_pin_slew(pslw), .o_pin_drive(pdrv)
    );
    scl_core_mdl core_u (
        .i_clk(clk), .i_nrst(nrst), .i_stop_req(sreq), .i_deep_req(dreq),
        .i_deep_stop_allowed(deep_ok), .o_in_stop(in_stop), .o_in_deep_stop(in_deep)
    );
    // ************************************************************
    // Clocks; the 1 kHz source is scaled down to keep the run short
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial forever begin
        repeat (8) @(posedge clk);
        lpo <= lpo_on & ~lpo;
    end
    initial forever begin
        repeat (6) @(posedge clk);
        ext <= ext_on & ~ext;
    end
    // ************************************************************
    // Bus access and checking
    // ************************************************************
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        wr  <= w;
        rd  <= ~w;
        adr <= a;
        wd  <= d;
        do @(posedge clk); while (wait_rq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic rdc(input logic [4:0] a, input logic [31:0] e, input string s);
        bus(1'b0, a, 32'h0);
        chk(s, e, q);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic wait_irq;
        n = 0;
        while (rt_irq !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic summarize;
        if (fails == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Watchdog far beyond the expected run of some 3500 cycles
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        summarize();
    end
    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        {rd, wr, bh, wl, wh, lpo, ext, pd, ddr, slw, drv, sreq, dreq, lpo_on, ext_on} = '0;
        adr = '0;
        wd = '0;
        fails = 0;
        checks_done = 0;
        nrst = 1'b0;
        bl = 1'b1;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        cyc(6);
        chk("por_hold", 1, crst);
        @(posedge clk);
        bl <= 1'b0;
        cyc(3);
        chk("por_end", 0, crst);
        rdc(ADDR_CAUSE, 32'h03, "cause_por");
        rdc(ADDR_PMC1, 32'h05, "pmc1_rst");
        rdc(5'h14, 32'h00, "unmapped");
        @(posedge clk);
        sreq <= 1'b1;
        cyc(2);
        chk("det_stop", 0, det_on);
        bus(1'b1, ADDR_PMC1, 32'h0D);
        cyc(1);
        chk("det_keep", 1, det_on);
        chk("deep_ok", 0, deep_ok);
        @(posedge clk);
        dreq <= 1'b1;
        cyc(3);
        chk("deep_refused", 0, in_deep);
        bus(1'b1, ADDR_PMC1, 32'h0C);
        cyc(3);
        chk("det_off", 0, det_on);
        chk("deep_entered", 1, in_deep);
        @(posedge clk);
        {sreq, dreq} <= 2'b00;
        bus(1'b1, ADDR_PMC1, 32'h03);
        @(posedge clk);
        bl <= 1'b1;
        cyc(3);
        chk("lv_irq", 1, lv_irq);
        @(posedge clk);
        bl <= 1'b0;
        rdc(ADDR_PMC1, 32'h13, "lv_flag");
        bus(1'b1, ADDR_PMC1, 32'h23);
        cyc(2);
        chk("lv_irq_ack", 0, lv_irq);
        bus(1'b1, ADDR_PMC2, 32'h01);
        bus(1'b1, ADDR_PMC1, 32'h05);
        chk("lvl_hi", 1, lvl_hi);
        @(posedge clk);
        bh <= 1'b1;
        cyc(20);
        chk("lv_reset", 1, crst);
        @(posedge clk);
        bh <= 1'b0;
        cyc(3);
        chk("lv_release", 0, crst);
        rdc(ADDR_CAUSE, 32'h02, "cause_lv");
        rdc(ADDR_PMC2, 32'h01, "lvl_kept");
        bus(1'b1, ADDR_PMC2, 32'h02);
        @(posedge clk);
        wh <= 1'b1;
        cyc(3);
        chk("warn_noirq", 0, lv_irq | rt_irq);
        @(posedge clk);
        wh <= 1'b0;
        rdc(ADDR_PMC2, 32'h06, "warn_flag");
        bus(1'b1, ADDR_PMC2, 32'h0A);
        rdc(ADDR_PMC2, 32'h02, "warn_ack");
        lpo_on <= 1'b1;
        bus(1'b1, ADDR_RTI, 32'h09);
        wait_irq();
        chk("rti_8ticks", 1, {31'h0, n >= 100 && n <= 150});
        rdc(ADDR_RTI, 32'h29, "rti_flag");
        bus(1'b1, ADDR_RTI, 32'h40);
        rdc(ADDR_RTI, 32'h00, "rti_ack");
        bus(1'b1, ADDR_RTI, 32'h08);
        cyc(300);
        chk("rti_off", 0, rt_irq);
        bus(1'b1, ADDR_RTI, 32'h01);
        cyc(200);
        chk("rti_masked", 0, rt_irq);
        rdc(ADDR_RTI, 32'h21, "rti_flag_m");
        bus(1'b1, ADDR_RTI, 32'h40);
        lpo_on <= 1'b0;
        ext_on <= 1'b1;
        bus(1'b1, ADDR_RTI, 32'h19);
        wait_irq();
        chk("rti_ext", 1, rt_irq);
        @(posedge clk);
        dreq <= 1'b1;
        bus(1'b1, ADDR_RTI, 32'h59);
        cyc(300);
        chk("ext_deep", 0, rt_irq);
        lpo_on <= 1'b1;
        bus(1'b1, ADDR_RTI, 32'h49);
        wait_irq();
        chk("lpo_deep", 1, rt_irq);
        @(posedge clk);
        dreq <= 1'b0;
        slw <= 1'b1;
        for (int s = 0; s < 8; s++) begin
            bus(1'b1, ADDR_CLKO, {28'h0, s[2:0], 1'b1});
            cyc(2);
            n = 0;
            prev = pin;
            repeat (256) begin
                @(negedge clk);
                n += (pin !== prev);
                prev = pin;
            end
            chk("clk_toggles", (s == 0) ? 0 : (256 >> (s - 1)), n);
            chk("clk_oe", 1, oe);
            if (s == 0) chk("clk_low", 0, pin);
        end
        chk("pin_slew", 1, pslw);
        chk("pin_drive", 0, pdrv);
        @(posedge clk);
        {slw, drv, pd, ddr} <= 4'b0111;
        bus(1'b1, ADDR_CLKO, 32'h00);
        cyc(2);
        chk("pin_port", 32'h3, {pin, oe});
        chk("pin_sd", 32'h1, {pslw, pdrv});
        summarize();
    end
endmodule
`default_nettype wire
